// [common/nt_vc_pkg.sv]
/*
  Constants for the non-transparent port channel and arbitration register bank.
  Assumes a dword configuration access port on the core clock.
*/
package nt_vc_pkg;
  localparam logic [11:0] OFF_PORT_CAP1 = 12'h14C;
  localparam logic [11:0] OFF_PORT_CTRL = 12'h154;
  localparam logic [11:0] OFF_CH0_CAP = 12'h158;
  localparam logic [11:0] OFF_CH0_CTRL = 12'h15C;
  localparam logic [11:0] OFF_CH0_STAT = 12'h160;
  localparam logic [11:0] OFF_CH1_CAP = 12'h164;
  localparam logic [11:0] OFF_CH1_CTRL = 12'h168;
  localparam logic [11:0] OFF_CH1_STAT = 12'h16C;
  localparam logic [11:0] OFF_CH_TABLE = 12'h188;
  localparam logic [11:0] OFF_PORT_TABLE0 = 12'h198;
  localparam logic [11:0] OFF_PORT_TABLE1 = 12'h1A8;
  localparam logic [11:0] OFF_TUNE0 = 12'h844;
  localparam logic [11:0] OFF_TUNE1 = 12'h848;
  localparam logic [11:0] OFF_DISPLAY = 12'h84C;
  localparam logic [11:0] OFF_TUNE2 = 12'h854;
  localparam logic [11:0] OFF_CDR = 12'h858;
  localparam int TABLE_WORDS = 4;
  localparam logic [31:0] RST_TUNE0 = 32'h0400_1060;
  localparam logic [31:0] RST_TUNE1 = 32'h0400_0800;
  localparam logic [31:0] RST_TUNE2 = 32'h0000_0080;
  localparam logic [31:0] RST_CDR = 32'h0000_5600;
  localparam logic [31:0] MASK_TUNE2 = 32'h0000_7FFF;
  localparam logic [31:0] MASK_CDR = 32'h0000_1F00;
  localparam logic [7:0] RST_CH0_MAP = 8'hFF;
  localparam logic [7:0] RST_CH1_MAP = 8'h00;
  localparam logic [2:0] RST_CH1_ID = 3'h1;
  localparam logic [2:0] SEL_DEFAULT = 3'h0;
  localparam logic [2:0] SEL_WRR = 3'h3;
  localparam logic [2:0] SEL_TIME_WRR = 3'h4;
  localparam int CROSSLINK_BIT = 2;
  localparam int LOAD_BIT = 16;
  localparam int SEL_LSB = 17;
  localparam int STATUS_BIT = 16;
  localparam int PENDING_BIT = 17;
  localparam int CHID_LSB = 24;
  localparam int CHEN_BIT = 31;
  localparam logic [31:0] CAP1_VALUE = 32'h0000_0800;
  localparam logic [31:0] CH0_CAP_VALUE = 32'h053F_0003;
  localparam logic [31:0] CH1_CAP_VALUE = 32'h063F_0013;
  localparam logic [31:0] VC_CAP2_VALUE = 32'h0400_0003;
  localparam logic [31:0] VC_CAP2_NO_CH1 = 32'h0000_0003;
  localparam logic [11:0] OFF_VC_CAP2 = 12'h150;
  localparam int LOAD_CYCLES = 4;
endpackage : nt_vc_pkg

// [common/nt_load_if.sv]
/*
  Load handshake between the register bank and a table loader.
  Assumes both ends run on mclk.
*/
`timescale 1ns/100ps
`default_nettype none
interface nt_load_if;
  logic start;
  logic busy;
  logic done;
  modport bank (output start, input busy, input done);
  modport loader (input start, output busy, output done);
endinterface : nt_load_if
`default_nettype wire

// [core/nt_table_loader.sv]
/*
  Table loader: copies a programmed table into the active copy over a fixed
  number of cycles. Assumes start is a one-cycle pulse on mclk.
*/
`timescale 1ns/100ps
`default_nettype none
module nt_table_loader #(
  parameter int WIDTH = 128,
  parameter int CYCLES = 4
) (
  input wire logic mclk,
  input wire logic reset,
  nt_load_if.loader ld,
  input wire logic [WIDTH-1:0] programmed,
  output logic [WIDTH-1:0] active
);
  logic [7:0] count_reg, count_next;
  logic [WIDTH-1:0] active_reg, active_next;
  logic done_reg, done_next;

  // Count down, then latch the table in one go so users never see a mix
  always_comb begin
    count_next = count_reg;
    active_next = active_reg;
    done_next = 1'b0;
    if (ld.start && count_reg == 8'h00) begin
      count_next = 8'(CYCLES);
    end else if (count_reg == 8'h01) begin
      count_next = 8'h00;
      active_next = programmed;
      done_next = 1'b1;
    end else if (count_reg != 8'h00) begin
      count_next = count_reg - 8'h01;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      count_reg <= 8'h00;
      active_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      active_reg <= active_next;
      done_reg <= done_next;
    end
  end

  assign ld.busy = count_reg != 8'h00;
  assign ld.done = done_reg;
  assign active = active_reg;

  property p_load_done;
    @(posedge mclk) disable iff (reset)
      (ld.start && count_reg == 8'h00) |-> ##(CYCLES + 1) done_reg;
  endproperty
  a_load_done: assert property (p_load_done) else $error("load did not finish");
endmodule : nt_table_loader
`default_nettype wire

// [core/nt_vc_regs.sv]
/*
  Channel and arbitration register bank of the non-transparent port.
  Assumes a single-cycle dword configuration access port on mclk; the
  preload engine writes through the same port; negotiation status arrives
  from the link layer as asynchronous levels.
*/
`timescale 1ns/100ps
`default_nettype none
module nt_vc_regs #(
  parameter bit SECOND_CHANNEL_PRESENT = 1'b1,
  parameter int LOAD_LATENCY = nt_vc_pkg::LOAD_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic [1:0] negotiation_busy,
  output logic [7:0] ch0_class_map,
  output logic [7:0] ch1_class_map,
  output logic [2:0] ch0_port_select,
  output logic [2:0] ch1_port_select,
  output logic [2:0] ch1_id,
  output logic ch1_enable,
  output logic crosslink_enable,
  output logic display_decode_enable,
  output logic [2:0] channel_select,
  output logic [127:0] active_channel_table,
  output logic [127:0] active_port_table0,
  output logic [127:0] active_port_table1
);
  import nt_vc_pkg::*;

  logic [7:0] map0_reg, map0_next;
  logic [7:0] map1_reg, map1_next;
  logic [2:0] sel0_reg, sel0_next;
  logic [2:0] sel1_reg, sel1_next;
  logic [2:0] chsel_reg, chsel_next;
  logic [2:0] id1_reg, id1_next;
  logic en1_reg, en1_next;
  logic [31:0] tune0_reg, tune0_next;
  logic [31:0] tune1_reg, tune1_next;
  logic [31:0] tune2_reg, tune2_next;
  logic [31:0] cdr_reg, cdr_next;
  logic [31:0] chtab_reg [TABLE_WORDS];
  logic [31:0] chtab_next [TABLE_WORDS];
  logic [31:0] ptab0_reg [TABLE_WORDS];
  logic [31:0] ptab0_next [TABLE_WORDS];
  logic [31:0] ptab1_reg [TABLE_WORDS];
  logic [31:0] ptab1_next [TABLE_WORDS];
  logic st_ch_reg, st_ch_next;
  logic st_p0_reg, st_p0_next;
  logic st_p1_reg, st_p1_next;
  logic [31:0] rdata_reg, rdata_next;
  logic rvalid_reg;
  logic [1:0] neg_meta_reg, neg_sync_reg;
  logic [1:0] tab_word;
  logic hit_ch, hit_p0, hit_p1;
  logic load_ch, load_p0, load_p1;
  logic [127:0] chtab_flat, ptab0_flat, ptab1_flat;

  nt_load_if ch_ld ();
  nt_load_if p0_ld ();
  nt_load_if p1_ld ();

  // Table word decode; each table spans four dwords
  always_comb begin
    tab_word = cfg_addr[3:2];
    hit_ch = (cfg_addr >= OFF_CH_TABLE) && (cfg_addr < OFF_CH_TABLE + 12'h010);
    hit_p0 = (cfg_addr >= OFF_PORT_TABLE0) && (cfg_addr < OFF_PORT_TABLE0 + 12'h010);
    hit_p1 = (cfg_addr >= OFF_PORT_TABLE1) && (cfg_addr < OFF_PORT_TABLE1 + 12'h010);
    tab_word = 2'(cfg_addr[3:2] - (hit_ch ? OFF_CH_TABLE[3:2] : OFF_PORT_TABLE0[3:2]));
  end

  // Load strobes are pulses only; nothing holds them, so they read as zero
  always_comb begin
    load_ch = cfg_wr && cfg_addr == OFF_PORT_CTRL && cfg_wdata[0];
    load_p0 = cfg_wr && cfg_addr == OFF_CH0_CTRL && cfg_wdata[LOAD_BIT];
    load_p1 = cfg_wr && cfg_addr == OFF_CH1_CTRL && cfg_wdata[LOAD_BIT];
  end

  assign ch_ld.start = load_ch;
  assign p0_ld.start = load_p0;
  assign p1_ld.start = load_p1;

  // Control and tuning registers
  always_comb begin
    map0_next = map0_reg;
    map1_next = map1_reg;
    sel0_next = sel0_reg;
    sel1_next = sel1_reg;
    chsel_next = chsel_reg;
    id1_next = id1_reg;
    en1_next = en1_reg;
    tune0_next = tune0_reg;
    tune1_next = tune1_reg;
    tune2_next = tune2_reg;
    cdr_next = cdr_reg;
    if (cfg_wr) begin
      case (cfg_addr)
        OFF_PORT_CTRL: begin
          chsel_next = (cfg_wdata[3:1] == 3'h1) ? 3'h1 : SEL_DEFAULT;
        end
        OFF_CH0_CTRL: begin
          map0_next = cfg_wdata[7:0];
          // Unsupported schemes fall back rather than being stored
          if (cfg_wdata[SEL_LSB+:3] == SEL_WRR) begin
            sel0_next = SEL_WRR;
          end else begin
            sel0_next = SEL_DEFAULT;
          end
        end
        OFF_CH1_CTRL: begin
          map1_next = {cfg_wdata[7:1], 1'b0};
          if (cfg_wdata[SEL_LSB+:3] == SEL_WRR || cfg_wdata[SEL_LSB+:3] == SEL_TIME_WRR) begin
            sel1_next = cfg_wdata[SEL_LSB+:3];
          end else begin
            sel1_next = SEL_DEFAULT;
          end
          id1_next = cfg_wdata[CHID_LSB+:3];
          en1_next = cfg_wdata[CHEN_BIT];
        end
        OFF_TUNE0: tune0_next = cfg_wdata;
        OFF_TUNE1: tune1_next = cfg_wdata;
        OFF_TUNE2: tune2_next = cfg_wdata & MASK_TUNE2;
        OFF_CDR: cdr_next = cfg_wdata & MASK_CDR;
        default: begin
        end
      endcase
    end
  end

  // Table arrays and their status flags; a write in the finishing cycle wins
  always_comb begin
    for (int i = 0; i < TABLE_WORDS; i++) begin
      chtab_next[i] = chtab_reg[i];
      ptab0_next[i] = ptab0_reg[i];
      ptab1_next[i] = ptab1_reg[i];
    end
    st_ch_next = st_ch_reg;
    st_p0_next = st_p0_reg;
    st_p1_next = st_p1_reg;
    if (ch_ld.done) st_ch_next = 1'b0;
    if (p0_ld.done) st_p0_next = 1'b0;
    if (p1_ld.done) st_p1_next = 1'b0;
    if (cfg_wr && hit_ch) begin
      chtab_next[tab_word] = cfg_wdata & 32'h7777_7777;
      st_ch_next = 1'b1;
    end
    if (cfg_wr && hit_p0) begin
      ptab0_next[tab_word] = cfg_wdata & 32'h3333_3333;
      st_p0_next = 1'b1;
    end
    if (cfg_wr && hit_p1) begin
      ptab1_next[tab_word] = cfg_wdata & 32'h3333_3333;
      st_p1_next = 1'b1;
    end
  end

  // Read mux; tuning words hold state but never show it
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (cfg_rd) begin
      case (cfg_addr)
        OFF_PORT_CAP1: rdata_next = CAP1_VALUE;
        OFF_VC_CAP2: rdata_next = SECOND_CHANNEL_PRESENT ? VC_CAP2_VALUE : VC_CAP2_NO_CH1;
        OFF_PORT_CTRL: rdata_next = {15'h0000, st_ch_reg, 12'h000, chsel_reg, 1'b0};
        OFF_CH0_CAP: rdata_next = CH0_CAP_VALUE;
        OFF_CH0_CTRL: begin
          rdata_next = {1'b1, 4'h0, 3'h0, 4'h0, sel0_reg, 1'b0, 8'h00, map0_reg};
        end
        OFF_CH0_STAT: rdata_next = {14'h0000, neg_sync_reg[0], st_p0_reg, 16'h0000};
        OFF_CH1_CAP: begin
          rdata_next = SECOND_CHANNEL_PRESENT ? CH1_CAP_VALUE : 32'h0000_0000;
        end
        OFF_CH1_CTRL: begin
          rdata_next = {en1_reg, 4'h0, id1_reg, 4'h0, sel1_reg, 1'b0, 8'h00, map1_reg};
        end
        OFF_CH1_STAT: rdata_next = {14'h0000, neg_sync_reg[1], st_p1_reg, 16'h0000};
        default: begin
          if (hit_ch) rdata_next = chtab_reg[tab_word];
          else if (hit_p0) rdata_next = ptab0_reg[tab_word];
          else if (hit_p1) rdata_next = ptab1_reg[tab_word];
        end
      endcase
    end
  end

  // Register stage
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      map0_reg <= RST_CH0_MAP;
      map1_reg <= RST_CH1_MAP;
      sel0_reg <= SEL_DEFAULT;
      sel1_reg <= SEL_DEFAULT;
      chsel_reg <= SEL_DEFAULT;
      id1_reg <= SECOND_CHANNEL_PRESENT ? RST_CH1_ID : 3'h0;
      en1_reg <= 1'b0;
      tune0_reg <= RST_TUNE0;
      tune1_reg <= RST_TUNE1;
      tune2_reg <= RST_TUNE2;
      cdr_reg <= RST_CDR;
      for (int i = 0; i < TABLE_WORDS; i++) begin
        chtab_reg[i] <= 32'h0000_0000;
        ptab0_reg[i] <= 32'h0000_0000;
        ptab1_reg[i] <= 32'h0000_0000;
      end
      st_ch_reg <= 1'b0;
      st_p0_reg <= 1'b0;
      st_p1_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
      neg_meta_reg <= 2'h0;
      neg_sync_reg <= 2'h0;
    end else begin
      map0_reg <= map0_next;
      map1_reg <= map1_next;
      sel0_reg <= sel0_next;
      sel1_reg <= sel1_next;
      chsel_reg <= chsel_next;
      id1_reg <= id1_next;
      en1_reg <= en1_next;
      tune0_reg <= tune0_next;
      tune1_reg <= tune1_next;
      tune2_reg <= tune2_next;
      cdr_reg <= cdr_next;
      for (int i = 0; i < TABLE_WORDS; i++) begin
        chtab_reg[i] <= chtab_next[i];
        ptab0_reg[i] <= ptab0_next[i];
        ptab1_reg[i] <= ptab1_next[i];
      end
      st_ch_reg <= st_ch_next;
      st_p0_reg <= st_p0_next;
      st_p1_reg <= st_p1_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= cfg_rd;
      neg_meta_reg <= negotiation_busy; // Pins come from the link layer domain
      neg_sync_reg <= neg_meta_reg;
    end
  end

  assign chtab_flat = {chtab_reg[3], chtab_reg[2], chtab_reg[1], chtab_reg[0]};
  assign ptab0_flat = {ptab0_reg[3], ptab0_reg[2], ptab0_reg[1], ptab0_reg[0]};
  assign ptab1_flat = {ptab1_reg[3], ptab1_reg[2], ptab1_reg[1], ptab1_reg[0]};

  // One loader per table, so loads of different tables may overlap
  nt_table_loader #(.WIDTH(128), .CYCLES(LOAD_LATENCY)) u_ch_loader (
    .mclk(mclk), .reset(reset), .ld(ch_ld), .programmed(chtab_flat),
    .active(active_channel_table));
  nt_table_loader #(.WIDTH(128), .CYCLES(LOAD_LATENCY)) u_p0_loader (
    .mclk(mclk), .reset(reset), .ld(p0_ld), .programmed(ptab0_flat),
    .active(active_port_table0));
  nt_table_loader #(.WIDTH(128), .CYCLES(LOAD_LATENCY)) u_p1_loader (
    .mclk(mclk), .reset(reset), .ld(p1_ld), .programmed(ptab1_flat),
    .active(active_port_table1));

  // Flop-driven outputs, except display_decode_enable, which is tied high
  assign cfg_rdata = rdata_reg;
  assign cfg_rvalid = rvalid_reg;
  assign ch0_class_map = map0_reg;
  assign ch1_class_map = map1_reg;
  assign ch0_port_select = sel0_reg;
  assign ch1_port_select = sel1_reg;
  assign channel_select = chsel_reg;
  assign ch1_id = id1_reg;
  assign ch1_enable = en1_reg;
  assign crosslink_enable = tune0_reg[CROSSLINK_BIT];
  assign display_decode_enable = 1'b1;

  property p_map1_bit0;
    @(posedge mclk) disable iff (reset) cfg_wr && cfg_addr == OFF_CH1_CTRL |=> !map1_reg[0];
  endproperty
  a_map1_bit0: assert property (p_map1_bit0) else $error("class 0 on channel 1");

  property p_map0_write;
    @(posedge mclk) disable iff (reset)
      cfg_wr && cfg_addr == OFF_CH0_CTRL |=> map0_reg == $past(cfg_wdata[7:0]);
  endproperty
  a_map0_write: assert property (p_map0_write) else $error("channel 0 map lost");

  property p_sel0_legal;
    @(posedge mclk) disable iff (reset) sel0_reg == SEL_DEFAULT || sel0_reg == SEL_WRR;
  endproperty
  a_sel0_legal: assert property (p_sel0_legal) else $error("illegal channel 0 select");

  property p_sel1_legal;
    @(posedge mclk) disable iff (reset)
      sel1_reg == SEL_DEFAULT || sel1_reg == SEL_WRR || sel1_reg == SEL_TIME_WRR;
  endproperty
  a_sel1_legal: assert property (p_sel1_legal) else $error("illegal channel 1 select");

  property p_p0_status_set;
    @(posedge mclk) disable iff (reset) cfg_wr && hit_p0 |=> st_p0_reg;
  endproperty
  a_p0_status_set: assert property (p_p0_status_set) else $error("status not set");

  property p_tune_reads_zero;
    @(posedge mclk) disable iff (reset)
      cfg_rd && (cfg_addr == OFF_TUNE0 || cfg_addr == OFF_DISPLAY) |=> cfg_rdata == 32'h0;
  endproperty
  a_tune_reads_zero: assert property (p_tune_reads_zero) else $error("tuning nonzero");

  property p_ctrl_load_zero;
    @(posedge mclk) disable iff (reset) cfg_rd && cfg_addr == OFF_CH0_CTRL
      |=> !cfg_rdata[LOAD_BIT] && cfg_rdata[CHEN_BIT] && cfg_rdata[26:24] == 3'h0;
  endproperty
  a_ctrl_load_zero: assert property (p_ctrl_load_zero) else $error("ctrl 0 readback");

  property p_pending_follows;
    @(posedge mclk) disable iff (reset)
      negotiation_busy[0] [*3] |-> neg_sync_reg[0];
  endproperty
  a_pending_follows: assert property (p_pending_follows) else $error("pending lost");

  // A finished load clears the flag unless a table write lands in that cycle
  property p_ch_clear;
    @(posedge mclk) disable iff (reset) ch_ld.done && !(cfg_wr && hit_ch) |=> !st_ch_reg;
  endproperty
  a_ch_clear: assert property (p_ch_clear) else $error("channel status stuck");

  property p_p1_clear;
    @(posedge mclk) disable iff (reset) p1_ld.done && !(cfg_wr && hit_p1) |=> !st_p1_reg;
  endproperty
  a_p1_clear: assert property (p_p1_clear) else $error("port 1 status stuck");

  property p_xlink_write;
    @(posedge mclk) disable iff (reset) cfg_wr && cfg_addr == OFF_TUNE0
      |=> crosslink_enable == $past(cfg_wdata[CROSSLINK_BIT]);
  endproperty
  a_xlink_write: assert property (p_xlink_write) else $error("crosslink lost");

  property p_ch1_read;
    @(posedge mclk) disable iff (reset) cfg_rd && cfg_addr == OFF_CH1_CTRL
      |=> !cfg_rdata[LOAD_BIT] && !cfg_rdata[0] && cfg_rdata[30:27] == 4'h0;
  endproperty
  a_ch1_read: assert property (p_ch1_read) else $error("ctrl 1 readback");

  // Bit 3 of every phase nibble is reserved and must never come back
  property p_chtab_rsvd;
    @(posedge mclk) disable iff (reset)
      cfg_rd && hit_ch |=> (cfg_rdata & 32'h8888_8888) == 32'h0000_0000;
  endproperty
  a_chtab_rsvd: assert property (p_chtab_rsvd) else $error("phase reserved bit");
endmodule : nt_vc_regs
`default_nettype wire

// [sim/testbench.sv]
/*
  Self-checking bench for the channel and arbitration register bank.
  Two builds of the bank share mclk and the config port driven here.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import nt_vc_pkg::*;
  localparam int LAT = 4;
  logic mclk, reset, cfg_wr, cfg_rd, cfg_rvalid;
  logic ch1_enable, crosslink_enable, display_decode_enable;
  logic [11:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, d, r, rdata_single;
  logic [1:0] negotiation_busy;
  logic [7:0] ch0_class_map, ch1_class_map;
  logic [2:0] ch0_port_select, ch1_port_select, ch1_id, channel_select, id_single;
  logic [127:0] active_channel_table, active_port_table0, active_port_table1;
  int fail_count, samples_checked, seed_value, i, k;

  nt_vc_regs #(.SECOND_CHANNEL_PRESENT(1'b1), .LOAD_LATENCY(LAT)) uut (
    .mclk(mclk), .reset(reset), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .negotiation_busy(negotiation_busy),
    .ch0_class_map(ch0_class_map), .ch1_class_map(ch1_class_map),
    .ch0_port_select(ch0_port_select), .ch1_port_select(ch1_port_select),
    .ch1_id(ch1_id), .ch1_enable(ch1_enable), .crosslink_enable(crosslink_enable),
    .display_decode_enable(display_decode_enable), .channel_select(channel_select),
    .active_channel_table(active_channel_table),
    .active_port_table0(active_port_table0), .active_port_table1(active_port_table1)
  );

  // Build without the second channel, fastest loads; shares the config port
  nt_vc_regs #(.SECOND_CHANNEL_PRESENT(1'b0), .LOAD_LATENCY(1)) uut_single (
    .mclk(mclk), .reset(reset), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(rdata_single),
    .cfg_rvalid(), .negotiation_busy(negotiation_busy),
    .ch0_class_map(), .ch1_class_map(), .ch0_port_select(), .ch1_port_select(),
    .ch1_id(id_single), .ch1_enable(), .crosslink_enable(), .display_decode_enable(),
    .channel_select(), .active_channel_table(), .active_port_table0(),
    .active_port_table1()
  );

  // Free-running core clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Expected select after filtering illegal codes
  function automatic logic [2:0] sel0(input logic [2:0] s);
    return (s == SEL_WRR) ? s : SEL_DEFAULT;
  endfunction : sel0

  function automatic logic [2:0] sel1(input logic [2:0] s);
    return (s == SEL_WRR || s == SEL_TIME_WRR) ? s : SEL_DEFAULT;
  endfunction : sel1

  // Readback of control words; load bit and reserved bits always zero
  function automatic logic [31:0] exp0(input logic [31:0] v);
    return {1'b1, 11'h000, sel0(v[19:17]), 1'b0, 8'h00, v[7:0]};
  endfunction : exp0

  function automatic logic [31:0] exp1(input logic [31:0] v);
    return {v[31], 4'h0, v[26:24], 4'h0, sel1(v[19:17]), 1'b0, 8'h00, v[7:1], 1'b0};
  endfunction : exp1

  function automatic logic [127:0] act(input int w);
    return (w == 0) ? active_port_table0 : (w == 1) ? active_port_table1 : active_channel_table;
  endfunction : act

  task automatic stop_test();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Writes are held one full cycle, then a gap cycle before the next
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(negedge mclk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = v;
    @(negedge mclk);
    cfg_wr = 1'b0;
  endtask : wr

  // Read answer is looked at in the one cycle that rvalid stands
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(negedge mclk);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge mclk);
    chk(cfg_rvalid, 1'b1);
    v = cfg_rdata;
    cfg_rd = 1'b0;
  endtask : rd

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(v, e);
  endtask : rdchk

  // Fill a table, see status rise, then load and see the active copy follow
  task automatic table_load(input logic [11:0] base, input logic [11:0] ctl,
                            input logic [11:0] st, input logic [31:0] mask,
                            input logic [31:0] cv, input int w);
    logic [127:0] old, tbl;
    old = act(w);
    for (int n = 0; n < TABLE_WORDS; n++) begin
      d = $urandom();
      tbl[n*32 +: 32] = d & mask;
      wr(base + 12'(4 * n), d);
      rdchk(base + 12'(4 * n), d & mask);
    end
    rdchk(st, 32'h0001_0000);
    chk(act(w), old);
    wr(ctl, cv);
    repeat (LAT + 2) @(negedge mclk);
    chk(act(w), tbl);
    rdchk(st, 32'h0000_0000);
  endtask : table_load

  // Watchdog at 20000 cycles; the whole sequence needs a few hundred cycles
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end

  initial begin
    reset = 1'b1;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 12'h000;
    cfg_wdata = 32'h0000_0000;
    negotiation_busy = 2'b00;
    fail_count = 0;
    samples_checked = 0;
    seed_value = $urandom(24680);
    repeat (6) @(negedge mclk);
    reset = 1'b0;
    // Reset state at the ports and in the register map
    chk(ch0_class_map, 8'hFF);
    chk(ch1_class_map, 8'h00);
    chk({ch1_enable, ch1_id}, 4'h1);
    chk(id_single, 3'h0);
    chk(crosslink_enable, 1'b0);
    chk(display_decode_enable, 1'b1);
    chk(active_port_table0, 128'h0);
    chk(active_port_table1, 128'h0);
    chk(active_channel_table, 128'h0);
    rdchk(OFF_CH0_CTRL, 32'h8000_00FF);
    rdchk(OFF_CH1_CTRL, 32'h0100_0000);
    chk(rdata_single, 32'h0000_0000);
    rdchk(OFF_CH0_CAP, {8'h05, 1'b0, 7'h3F, 16'h0003});
    rdchk(OFF_CH1_CAP, {8'h06, 1'b0, 7'h3F, 16'h0013});
    chk(rdata_single, 32'h0000_0000);
    rdchk(OFF_PORT_CAP1, 32'h0000_0800);
    rdchk(OFF_CH0_STAT, 32'h0000_0000);
    rdchk(OFF_CH1_STAT, 32'h0000_0000);
    rdchk(12'h000, 32'h0000_0000);
    for (k = 0; k < TABLE_WORDS; k++) begin
      rdchk(OFF_CH_TABLE + 12'(4 * k), 32'h0);
      rdchk(OFF_PORT_TABLE0 + 12'(4 * k), 32'h0);
      rdchk(OFF_PORT_TABLE1 + 12'(4 * k), 32'h0);
    end
    // Tuning words and display decode take writes but read zero
    for (k = 0; k < 5; k++) begin
      cfg_addr = (k == 0) ? OFF_TUNE1 : (k == 1) ? OFF_TUNE2 : (k == 2) ? OFF_CDR :
                 (k == 3) ? OFF_DISPLAY : OFF_TUNE0;
      r = {20'h0, cfg_addr};
      wr(r[11:0], $urandom());
      rdchk(r[11:0], 32'h0000_0000);
    end
    wr(OFF_TUNE0, 32'h0000_0004);
    chk(crosslink_enable, 1'b1);
    wr(OFF_TUNE0, RST_TUNE0);
    chk({crosslink_enable, display_decode_enable}, 2'b01);
    // Every select code on both channels
    for (k = 0; k < 8; k++) begin
      wr(OFF_CH0_CTRL, {12'h000, k[2:0], 17'h000FF});
      chk(ch0_port_select, sel0(k[2:0]));
      wr(OFF_CH1_CTRL, {12'h000, k[2:0], 17'h00000});
      chk(ch1_port_select, sel1(k[2:0]));
    end
    // Random control words, reserved and read-only bits included
    for (i = 0; i < 24; i++) begin
      d = (i == 0) ? 32'hFFFF_FFFF : $urandom();
      wr(OFF_CH0_CTRL, d);
      rdchk(OFF_CH0_CTRL, exp0(d));
      chk(ch0_class_map, d[7:0]);
      wr(OFF_CH1_CTRL, d);
      rdchk(OFF_CH1_CTRL, exp1(d));
      chk({ch1_enable, ch1_id, ch1_class_map}, {d[31], d[26:24], d[7:1], 1'b0});
    end
    repeat (LAT + 2) @(negedge mclk);
    table_load(OFF_PORT_TABLE0, OFF_CH0_CTRL, OFF_CH0_STAT, 32'h3333_3333,
               32'h0001_00FF, 0);
    table_load(OFF_PORT_TABLE1, OFF_CH1_CTRL, OFF_CH1_STAT, 32'h3333_3333,
               32'h8101_00FE, 1);
    table_load(OFF_CH_TABLE, OFF_PORT_CTRL, OFF_PORT_CTRL, 32'h7777_7777,
               32'h0000_0001, 2);
    // Channel select keeps code 001 only; reserved and status bits ignore writes
    wr(OFF_PORT_CTRL, 32'hFFFE_FFF2);
    chk(channel_select, 3'h1);
    rdchk(OFF_PORT_CTRL, 32'h0000_0002);
    wr(OFF_PORT_CTRL, 32'h0000_0004);
    chk(channel_select, 3'h0);
    // Negotiation pending follows each channel's busy level
    for (i = 0; i < 3; i++) begin
      negotiation_busy = (i == 2) ? 2'b00 : 2'(i + 1);
      repeat (4) @(negedge mclk);
      rdchk(OFF_CH0_STAT, {14'h0, negotiation_busy[0], 17'h0});
      rdchk(OFF_CH1_STAT, {14'h0, negotiation_busy[1], 17'h0});
    end
    stop_test();
  end
endmodule : testbench
`default_nettype wire
